// ===== design/kww_watchdog.sv
//
// Summary of operation
// - mode writes need key 0x37 in top byte; key reads zero
// - divide select picks low_freq_clock divisor 2,4,8,16,32,128,256,1024
// - 16-bit preload value copied into counter on every restart
// - expiry config writes need 12-bit key 0x234; key reads zero
// - counter runs only while counter_enable is one
// - internal reset on expiry only when reset_on_expiry is set
// - clear register: bit 0 clears window flag, bit 1 expiry flag
// - state register bit 1 sticky expiry, bit 0 sticky window flag
// - state bit 8 is one while counter is at or below window
// - state bit 9 is one while a restart is still executing
// - mask holds one enable per source; only enabled ones interrupt
// - window writes need key 0x91 in top byte; key reads zero
// - restart_only_in_window set allows restarts only inside window
// - restart_only_in_window never stops the window flag
// - 16-bit window length is the threshold for entry and restart
// - decrement per divided tick; at zero expire, reload, keep going
// - restart by writing key 0xC071; other values do nothing
// - expiry with reset enabled gives an 8-cycle unbreakable pulse
// - restarts ignored for two divided ticks plus half low clock
//
// Design decision made here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "kww_defs.svh"

module kww_watchdog
    import kww_pkg::*;
#(
    parameter int DIV_W = 10
) (
    input  wire logic      i_clk,
    input  wire logic      i_rst_n,
    input  wire logic      i_lf_clk,
    input  wire kww_bus_t  i_bus,
    output logic [31:0]    o_rdata,
    output logic           o_irq,
    output logic           o_sys_rst
);

    // ----------------------------------------
    // declarations
    // ----------------------------------------
    logic          lf_q_r;
    logic          lf_rise;
    logic          lf_edge;
    logic          tick;

    logic [2:0]    div_sel_r;
    logic [15:0]   preload_r;
    logic          enable_r;
    logic          rst_on_exp_r;
    logic          only_win_r;
    logic [15:0]   win_len_r;
    kww_flags_t    mask_r;
    kww_flags_t    flags_r;
    kww_flags_t    flags_nxt;
    kww_flags_t    ev;
    kww_flags_t    clr;
    logic [15:0]   cnt_r;
    logic          in_win;
    logic          restart_ok;
    logic          exp_start;

    kww_rs_state_t rs_r;
    logic [1:0]    guard_r;

    logic [31:0]   rd_word;

    // the prescaler needs ten bits for the slowest divisor
    if (DIV_W < 10)
    begin : g_div_w_chk
        $error("kww_watchdog: DIV_W below 10");
    end

    // ----------------------------------------
    // bus decode helper
    // ----------------------------------------
    function automatic logic wr_at(
        input kww_bus_t   b,
        input logic [11:0] ofs
    );
        wr_at = b.wr && (b.addr == ofs);
    endfunction

    // ----------------------------------------
    // low_freq_clock edges
    // ----------------------------------------

    // the input is taken as synchronous, so one stage is enough
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            lf_q_r <= 1'b0;
        else
            lf_q_r <= i_lf_clk;
    end

    assign lf_rise = i_lf_clk && !lf_q_r;
    assign lf_edge = i_lf_clk != lf_q_r;   // either edge, half a period

    // divided_count_clock as a one-cycle enable
    kww_divider #(
        .DIV_W (DIV_W)
    ) u_div (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_lf_rise (lf_rise),
        .i_sel     (div_sel_r),
        .o_tick    (tick)
    );

    // ----------------------------------------
    // keyed configuration registers
    // ----------------------------------------

    // mode: divide select and preload value
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            div_sel_r <= 3'(`KWW_MODE_RESET);
            preload_r <= 16'(`KWW_MODE_RESET >> `KWW_VAL_LO);
        end
        else if (wr_at(i_bus, `KWW_OFS_MODE) &&
                 i_bus.wdata[`KWW_KEY8_HI:`KWW_KEY8_LO] == `KWW_MODE_KEY)
        begin
            div_sel_r <= i_bus.wdata[2:0];
            preload_r <= i_bus.wdata[`KWW_VAL_HI:`KWW_VAL_LO];
        end
    end

    // expiry config: enable and reset-on-expiry
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            enable_r     <= 1'b0;
            rst_on_exp_r <= 1'b0;
        end
        else if (wr_at(i_bus, `KWW_OFS_EXPIRY_CFG) &&
                 i_bus.wdata[`KWW_KEY12_HI:`KWW_KEY12_LO] == `KWW_EXPIRY_KEY)
        begin
            enable_r     <= i_bus.wdata[`KWW_ENABLE_BIT];
            rst_on_exp_r <= i_bus.wdata[`KWW_RST_ON_EXP_BIT];
        end
    end

    // window: length and restart restriction
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            only_win_r <= 1'b0;
            win_len_r  <= 16'h0000;
        end
        else if (wr_at(i_bus, `KWW_OFS_WINDOW) &&
                 i_bus.wdata[`KWW_KEY8_HI:`KWW_KEY8_LO] == `KWW_WINDOW_KEY)
        begin
            only_win_r <= i_bus.wdata[`KWW_ONLY_WIN_BIT];
            win_len_r  <= i_bus.wdata[`KWW_VAL_HI:`KWW_VAL_LO];
        end
    end

    // ----------------------------------------
    // interrupt mask
    // ----------------------------------------

    // set has priority when both arrive, though strobes never overlap
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            mask_r <= '0;
        else if (wr_at(i_bus, `KWW_OFS_IRQ_SET))
            mask_r <= mask_r | kww_flags_t'(i_bus.wdata[1:0]);
        else if (wr_at(i_bus, `KWW_OFS_IRQ_CLEAR))
            mask_r <= mask_r & ~kww_flags_t'(i_bus.wdata[1:0]);
    end

    // ----------------------------------------
    // restart qualification
    // ----------------------------------------

    assign in_win = cnt_r <= win_len_r;

    // a restart is taken only when idle and inside any required window
    assign restart_ok = wr_at(i_bus, `KWW_OFS_RESTART) &&
                        i_bus.wdata[15:0] == `KWW_RESTART_KEY &&
                        rs_r == KWW_RS_IDLE &&
                        (!only_win_r || in_win);

    // guard sequence: two divided ticks, then the next low clock edge
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
        begin
            rs_r    <= KWW_RS_IDLE;
            guard_r <= 2'h0;
        end
        else
        begin
            case (rs_r)
                KWW_RS_IDLE:
                begin
                    if (restart_ok)
                    begin
                        rs_r    <= KWW_RS_TICKS;
                        guard_r <= 2'h0;
                    end
                end
                KWW_RS_TICKS:
                begin
                    if (tick)
                    begin
                        guard_r <= guard_r + 2'h1;
                        if (guard_r + 2'h1 == `KWW_GUARD_TICKS)
                            rs_r <= KWW_RS_HALF;
                    end
                end
                KWW_RS_HALF:
                begin
                    if (lf_edge)
                        rs_r <= KWW_RS_IDLE;
                end
                default:
                    rs_r <= KWW_RS_IDLE;
            endcase
        end
    end

    // ----------------------------------------
    // down-counter
    // ----------------------------------------

    // events are void in a cycle that restarts the count
    assign ev.expiry = enable_r && tick && !restart_ok &&
                       cnt_r == 16'h0000;
    assign ev.window = enable_r && tick && !restart_ok &&
                       cnt_r != 16'h0000 &&
                       cnt_r - 16'h0001 == win_len_r;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            cnt_r <= 16'(`KWW_MODE_RESET >> `KWW_VAL_LO);
        else if (restart_ok)
            cnt_r <= preload_r;
        else if (enable_r && tick)
        begin
            if (cnt_r == 16'h0000)
                cnt_r <= preload_r;
            else
                cnt_r <= cnt_r - 16'h0001;
        end
    end

    // ----------------------------------------
    // expiry action
    // ----------------------------------------

    assign exp_start = ev.expiry && rst_on_exp_r;

    kww_reset_pulse u_pulse (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_start (exp_start),
        .o_pulse (o_sys_rst)
    );

    // ----------------------------------------
    // sticky flags
    // ----------------------------------------

    assign clr = wr_at(i_bus, `KWW_OFS_FLAG_CLEAR) ?
                 kww_flags_t'(i_bus.wdata[1:0]) : '0;

    // a new event beats a clear in the same cycle
    assign flags_nxt = (flags_r & ~clr) | ev;

    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            flags_r <= '0;
        else
            flags_r <= flags_nxt;
    end

    // level request, held until software clears or masks
    assign o_irq = |(flags_r & mask_r);

    // ----------------------------------------
    // read path
    // ----------------------------------------

    // key fields and write-only registers read as zero
    always_comb
    begin
        rd_word = 32'h0000_0000;
        case (i_bus.addr)
            `KWW_OFS_MODE:
            begin
                rd_word[2:0] = div_sel_r;
                rd_word[`KWW_VAL_HI:`KWW_VAL_LO] = preload_r;
            end
            `KWW_OFS_EXPIRY_CFG:
            begin
                rd_word[`KWW_ENABLE_BIT]     = enable_r;
                rd_word[`KWW_RST_ON_EXP_BIT] = rst_on_exp_r;
            end
            `KWW_OFS_STATE:
            begin
                rd_word[1:0]            = flags_r;
                rd_word[`KWW_IN_WIN_BIT] = in_win;
                rd_word[`KWW_BUSY_BIT]  = rs_r != KWW_RS_IDLE;
            end
            `KWW_OFS_IRQ_VIEW:
                rd_word[1:0] = mask_r;
            `KWW_OFS_WINDOW:
            begin
                rd_word[`KWW_ONLY_WIN_BIT] = only_win_r;
                rd_word[`KWW_VAL_HI:`KWW_VAL_LO] = win_len_r;
            end
            default:
                rd_word = 32'h0000_0000;
        endcase
    end

    // data appears the cycle after the read strobe, and only then
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            o_rdata <= 32'h0000_0000;
        else if (i_bus.rd)
            o_rdata <= rd_word;
        else
            o_rdata <= 32'h0000_0000;
    end

endmodule
`default_nettype wire

// ===== design/kww_defs.svh
`ifndef KWW_DEFS_SVH
`define KWW_DEFS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define KWW_OFS_RESTART      12'h060
`define KWW_OFS_MODE         12'h064
`define KWW_OFS_EXPIRY_CFG   12'h068
`define KWW_OFS_FLAG_CLEAR   12'h06C
`define KWW_OFS_STATE        12'h070
`define KWW_OFS_IRQ_SET      12'h074
`define KWW_OFS_IRQ_CLEAR    12'h078
`define KWW_OFS_IRQ_VIEW     12'h07C
`define KWW_OFS_WINDOW       12'h080

// ----------------------------------------
// keys and field positions
// ----------------------------------------
`define KWW_MODE_KEY         8'h37
`define KWW_EXPIRY_KEY       12'h234
`define KWW_WINDOW_KEY       8'h91
`define KWW_RESTART_KEY      16'hC071
`define KWW_KEY8_HI          31
`define KWW_KEY8_LO          24
`define KWW_KEY12_HI         15
`define KWW_KEY12_LO         4
`define KWW_VAL_HI           23
`define KWW_VAL_LO           8
`define KWW_ENABLE_BIT       0
`define KWW_RST_ON_EXP_BIT   1
`define KWW_ONLY_WIN_BIT     0
`define KWW_IN_WIN_BIT       8
`define KWW_BUSY_BIT         9

// ----------------------------------------
// reset values and timing counts
// ----------------------------------------
`define KWW_MODE_RESET       32'h0007_FF00
`define KWW_PULSE_CYCLES     4'h8
`define KWW_GUARD_TICKS      2'h2

`endif

// ===== design/kww_pkg.sv
package kww_pkg;

    // register bus request, one word per cycle
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } kww_bus_t;

    // one bit per event source
    typedef struct packed {
        logic expiry;
        logic window;
    } kww_flags_t;

    // restart guard sequence
    typedef enum logic [1:0] {
        KWW_RS_IDLE  = 2'b00,
        KWW_RS_TICKS = 2'b01,
        KWW_RS_HALF  = 2'b10
    } kww_rs_state_t;

endpackage

// ===== design/kww_divider.sv
`timescale 1ns/10ps
`default_nettype none
`include "kww_defs.svh"

module kww_divider #(
    parameter int DIV_W = 10
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_lf_rise,
    input  wire logic [2:0] i_sel,
    output logic            o_tick
);

    logic [DIV_W-1:0] pre_r;

    // largest divisor needs ten bits of prescaler
    if (DIV_W < 10)
    begin : g_chk
        $error("kww_divider: DIV_W below 10");
    end

    // divisor minus one for each select code
    function automatic logic [DIV_W-1:0] last_of(input logic [2:0] s);
        case (s)
            3'h0:    last_of = DIV_W'(1);
            3'h1:    last_of = DIV_W'(3);
            3'h2:    last_of = DIV_W'(7);
            3'h3:    last_of = DIV_W'(15);
            3'h4:    last_of = DIV_W'(31);
            3'h5:    last_of = DIV_W'(127);
            3'h6:    last_of = DIV_W'(255);
            default: last_of = DIV_W'(1023);
        endcase
    endfunction

    assign o_tick = i_lf_rise && (pre_r >= last_of(i_sel));

    // --------------------------------
    // prescaler on low_freq_clock rising edges
    // --------------------------------
    // >= keeps a shrunk divisor from running out to wrap
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            pre_r <= '0;
        else if (o_tick)
            pre_r <= '0;
        else if (i_lf_rise)
            pre_r <= pre_r + DIV_W'(1);
    end

endmodule
`default_nettype wire

// ===== design/kww_reset_pulse.sv
`timescale 1ns/10ps
`default_nettype none
`include "kww_defs.svh"

module kww_reset_pulse (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_start,
    output logic      o_pulse
);

    logic [3:0] cnt_r;

    assign o_pulse = (cnt_r != 4'h0);

    // --------------------------------
    // eight-cycle pulse
    // --------------------------------
    // a running pulse ignores reset so it always completes
    always_ff @(posedge i_clk)
    begin
        if (i_start && i_rst_n)
            cnt_r <= `KWW_PULSE_CYCLES;
        else if (cnt_r inside {[4'h1:`KWW_PULSE_CYCLES]})
            cnt_r <= cnt_r - 4'h1;
        else
            cnt_r <= 4'h0;
    end

endmodule
`default_nettype wire

// ===== dv/kww_watchdog_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "kww_defs.svh"

module kww_watchdog_assertions
    import kww_pkg::*;
#(
    parameter int DIV_W = 10
) (
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_lf_clk,
    input wire kww_bus_t    i_bus,
    input wire logic [31:0] o_rdata,
    input wire logic        o_irq,
    input wire logic        o_sys_rst
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // ----
    // shadows rebuilt from bus writes, so reads can be judged
    // ----
    logic [1:0]  mask_r;
    logic [1:0]  cfg_r;
    logic        rv_r;
    logic [11:0] ra_r;

    // mask shadow: set and clear registers
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            mask_r <= 2'h0;
        else if (i_bus.wr && i_bus.addr == `KWW_OFS_IRQ_SET)
            mask_r <= mask_r | i_bus.wdata[1:0];
        else if (i_bus.wr && i_bus.addr == `KWW_OFS_IRQ_CLEAR)
            mask_r <= mask_r & ~i_bus.wdata[1:0];
    end

    // expiry config shadow: only keyed writes land
    always_ff @(posedge i_clk)
    begin
        if (!i_rst_n)
            cfg_r <= 2'h0;
        else if (i_bus.wr && i_bus.addr == `KWW_OFS_EXPIRY_CFG && i_bus.wdata[15:4] == 12'h234)
            cfg_r <= i_bus.wdata[1:0];
    end

    // which address the read data of this cycle belongs to
    always_ff @(posedge i_clk)
    begin
        rv_r <= i_rst_n && i_bus.rd;
        ra_r <= i_bus.addr;
    end

    // ----
    // properties
    // ----
    property p_rd_idle;
        !rv_r |-> o_rdata == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside read slot");

    property p_mode_key;
        rv_r && ra_r == 12'h064 |-> o_rdata[31:24] == 8'h00 && o_rdata[7:3] == 5'h00;
    endproperty
    a_mode_key: assert property (p_mode_key) else $error("mode key field not read as zero");

    property p_exp_key;
        rv_r && ra_r == 12'h068 |-> o_rdata[31:2] == 30'h0;
    endproperty
    a_exp_key: assert property (p_exp_key) else $error("expiry key field not read as zero");

    property p_win_key;
        rv_r && ra_r == 12'h080 |-> o_rdata[31:24] == 8'h00 && o_rdata[7:1] == 7'h00;
    endproperty
    a_win_key: assert property (p_win_key) else $error("window key field not read as zero");

    property p_state;
        rv_r && ra_r == 12'h070 |-> o_rdata[31:10] == 22'h0 && o_rdata[7:2] == 6'h00;
    endproperty
    a_state: assert property (p_state) else $error("state has bits outside its fields");

    property p_view;
        rv_r && ra_r == 12'h07C |-> o_rdata == 32'(mask_r);
    endproperty
    a_view: assert property (p_view) else $error("mask view differs from set and clear writes");

    property p_irq_mask;
        mask_r == 2'h0 |-> !o_irq;
    endproperty
    a_irq_mask: assert property (p_irq_mask) else $error("interrupt with every source masked");

    property p_pulse;
        $rose(o_sys_rst) |-> o_sys_rst[*8] ##1 !o_sys_rst;
    endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse not eight cycles");

    property p_pulse_cause;
        $rose(o_sys_rst) |-> cfg_r == 2'h3;
    endproperty
    a_pulse_cause: assert property (p_pulse_cause) else $error("reset pulse while not armed");
endmodule

bind kww_watchdog kww_watchdog_assertions #(.DIV_W(DIV_W)) u_kww_watchdog_assertions (
    .i_clk     (i_clk),
    .i_rst_n   (i_rst_n),
    .i_lf_clk  (i_lf_clk),
    .i_bus     (i_bus),
    .o_rdata   (o_rdata),
    .o_irq     (o_irq),
    .o_sys_rst (o_sys_rst)
);
`default_nettype wire

// ===== dv/kww_watchdog_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "kww_defs.svh"
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s exp %h got %h", n, e, g); end end

module kww_watchdog_tb
    import kww_pkg::*;
();
    logic        i_clk;
    logic        i_rst_n;
    logic        i_lf_clk;
    kww_bus_t    bus;
    logic [31:0] rdata;
    logic        irq;
    logic        sys_rst;
    logic        rst_q;
    logic [31:0] d;
    logic [31:0] r;
    logic [31:0] good;
    logic [15:0] p;
    int          fail_count;
    int          checked;
    int          rst_rises;
    int          cyc;
    int          n;
    int          k;
    int          divs [8] = '{2, 4, 8, 16, 32, 128, 256, 1024};
    logic [11:0] zofs [5] = '{12'h068, 12'h070, 12'h07C, 12'h080, 12'h000};
    logic [11:0] kofs [3] = '{12'h064, 12'h068, 12'h080};
    logic [31:0] rmsk [3] = '{32'h00FF_FF07, 32'h0000_0003, 32'h00FF_FF01};
    logic [31:0] kb [3] = '{32'h0100_0000, 32'h0000_0010, 32'h0100_0000};
    int          kw [3] = '{8, 12, 8};

    kww_watchdog #(.DIV_W(10)) u_kww_watchdog (
        .i_clk     (i_clk),
        .i_rst_n   (i_rst_n),
        .i_lf_clk  (i_lf_clk),
        .i_bus     (bus),
        .o_rdata   (rdata),
        .o_irq     (irq),
        .o_sys_rst (sys_rst)
    );

    // ----
    // clocks, monitors and expectations
    // ----
    initial
    begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    // low clock of four core cycles keeps divided periods short; counts reset pulses
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc % 2 == 1)
            i_lf_clk <= ~i_lf_clk;
        rst_q <= sys_rst;
        if (sys_rst === 1'b1 && rst_q === 1'b0)
            rst_rises <= rst_rises + 1;
    end

    function automatic int exp_period(logic [15:0] pv, int s);
        return (int'(pv) + 1) * divs[s] * 4;
    endfunction

    // puts the right key into a data word; enable bit kept low for the config
    function automatic logic [31:0] keyed(int i, logic [31:0] w);
        if (i == 0)
            return {8'h37, w[23:0]};
        if (i == 1)
            return {w[31:16], 12'h234, w[3:1], 1'b0};
        return {8'h91, w[23:0]};
    endfunction

    // ----
    // bus tasks and verdict
    // ----
    task automatic wr(input logic [11:0] a, input logic [31:0] w);
        @(posedge i_clk);
        bus <= '{a, w, 1'b1, 1'b0};
        @(posedge i_clk);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge i_clk);
        bus <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge i_clk);
        bus.rd <= 1'b0;
        #1 q = rdata;
    endtask

    // polls one state bit; each read costs two cycles
    task automatic poll(input int b, input logic v, output int c);
        c = 0;
        do
        begin
            rd(12'h070, d);
            c++;
        end while (d[b] !== v && c < 200);
    endtask

    task automatic wait_rise(output int c);
        int c0;
        c0 = rst_rises;
        c = 0;
        while (rst_rises == c0 && c < 30000)
        begin
            @(posedge i_clk);
            c++;
        end
    endtask

    task automatic give_verdict;
        $display("checked %0d fail_count %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // hang guard: the divide sweep needs about 35k cycles at worst, so cap at 60k
    initial
    begin
        #300000;
        fail_count++;
        $display("MISMATCH watchdog exp done got hang");
        give_verdict();
    end

    initial
    begin
        i_rst_n = 1'b0;
        i_lf_clk = 1'b0;
        bus = '0;
        cyc = 0;
        rst_q = 1'b0;
        rst_rises = 0;
        fail_count = 0;
        checked = 0;
        void'($urandom(32'hb7edfb3f));
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1'b1;
        // reset values; an unmapped write must vanish
        wr(12'h000, $urandom);
        rd(12'h064, d);
        `CHK("mode reset", 32'h0007_FF00, d)
        foreach (zofs[i])
        begin
            rd(zofs[i], d);
            `CHK("reset value", 32'h0000_0000, d)
        end
        // keyed writes land, a wrong key with new data is ignored whole
        foreach (kofs[i])
        begin
            r = $urandom;
            good = keyed(i, r);
            wr(kofs[i], good);
            rd(kofs[i], d);
            `CHK("keyed write", good & rmsk[i], d)
            wr(kofs[i], keyed(i, ~r) ^ (kb[i] << ($urandom % kw[i])));
            rd(kofs[i], d);
            `CHK("bad key", good & rmsk[i], d)
        end
        // mask set and clear
        wr(12'h074, 32'h0000_0003);
        rd(12'h07C, d);
        `CHK("mask set", 32'h0000_0003, d)
        wr(12'h078, 32'h0000_0001);
        rd(12'h07C, d);
        `CHK("mask clear", 32'h0000_0002, d)
        wr(12'h078, 32'h0000_0002);
        // every divide select, measured between two reset pulses
        wr(12'h080, 32'h91FF_FF00);
        wr(12'h068, 32'h0000_2343);
        for (int s = 0; s < 8; s++)
        begin
            p = 16'(1 + $urandom % 2);
            wr(12'h064, {8'h37, p, 5'h00, s[2:0]});
            wr(12'h060, 32'h0000_C071);
            wait_rise(n);
            wait_rise(n);
            `CHK("expiry period", exp_period(p, s), n)
        end
        // expiry without reset: flags, interrupt, masking, stop on disable
        wr(12'h068, 32'h0000_2341);
        n = rst_rises;
        wr(12'h064, 32'h3700_0500);
        wr(12'h080, 32'h9100_0200);
        wr(12'h060, 32'h0000_C071);
        // clear the sweep's stale flags before unmasking, or irq would show at once
        wr(12'h06C, 32'h0000_0003);
        wr(12'h074, 32'h0000_0002);
        k = 0;
        while (irq !== 1'b1 && k < 200)
        begin
            @(posedge i_clk);
            k++;
        end
        `CHK("irq after reload", 1'b1, irq)
        wr(12'h068, 32'h0000_2340);
        `CHK("no reset pulse", n, rst_rises)
        rd(12'h070, d);
        `CHK("both flags", 2'h3, d[1:0])
        wr(12'h06C, 32'h0000_0001);
        rd(12'h070, d);
        `CHK("window cleared", 2'h2, d[1:0])
        `CHK("irq expiry", 1'b1, irq)
        wr(12'h078, 32'h0000_0002);
        wr(12'h074, 32'h0000_0001);
        #1;
        `CHK("irq masked", 1'b0, irq)
        wr(12'h06C, 32'h0000_0002);
        repeat (100) @(posedge i_clk);
        rd(12'h070, d);
        `CHK("stopped counter", 2'h0, d[1:0])
        // restart guard, keys and window restriction
        wr(12'h064, 32'h3701_0000);
        wr(12'h080, 32'h9100_F000);
        wr(12'h068, 32'h0000_2341);
        wr(12'h060, 32'h0000_C071);
        poll(9, 1'b0, k);
        `CHK("guard length", 1'b1, k >= 5 && k <= 12)
        `CHK("above window", 1'b0, d[8])
        wr(12'h060, 32'h0000_C070);
        rd(12'h070, d);
        `CHK("wrong restart key", 1'b0, d[9])
        wr(12'h080, 32'h9100_F001);
        wr(12'h060, 32'h0000_C071);
        rd(12'h070, d);
        `CHK("restart outside window", 1'b0, d[9])
        poll(8, 1'b1, k);
        `CHK("inside window", 2'h3, {d[8], d[0]})
        wr(12'h060, 32'h0000_C071);
        rd(12'h070, d);
        `CHK("restart in window", 2'h2, d[9:8])
        // second reset in mid-run, driven on the edge while the guard is still busy
        @(posedge i_clk);
        i_rst_n <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        rd(12'h064, d);
        `CHK("mode after reset", 32'h0007_FF00, d)
        rd(12'h070, d);
        `CHK("state after reset", 32'h0000_0000, d)
        `CHK("irq after reset", 1'b0, irq)
        give_verdict();
    end
endmodule
`default_nettype wire
